/* logic/qpc_pkg.sv */
// package for the quadrature position counter: constants and carrier types
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package qpc_pkg;

  localparam int unsigned COUNT_W      = 16;
  localparam int unsigned TERM_W       = 8;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [1:0]  PHASE_RESET  = 2'h0;
  localparam int unsigned SYNC_STAGES  = 3;

  // phase pair as seen on the encoder pins
  typedef struct packed {
    logic phase_b;
    logic phase_a;
  } enc_phase_t;

  // monitored state: position and per-terminal on/off view
  typedef struct packed {
    logic [COUNT_W-1:0] encoder_position_monitor;
    logic [TERM_W-1:0]  input_state_monitor;
  } monitor_t;

endpackage

/* logic/quadrature_position_counter.sv */
// quadrature decoder and 16-bit wrapping position counter with terminal view
`timescale 1ns/1ps
module quadrature_position_counter #(
  parameter int unsigned TERMS = qpc_pkg::TERM_W
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  input  wire qpc_pkg::enc_phase_t  enc_in,
  input  wire logic [TERMS-1:0]     term_in,
  output qpc_pkg::monitor_t         monitor_out,
  output logic                      dir_reverse_out
);
  import qpc_pkg::*;

  // --------------------------------------------------------------------------
  // parameter checks
  // --------------------------------------------------------------------------
  // the monitor carrier has a fixed terminal field; any other width would
  // silently drop or pad terminals, so it is refused at elaboration
  if (TERMS != TERM_W)
  begin : g_terms_width
    $error("TERMS must equal the monitor terminal width");
  end

  // the filter below is written for exactly three stages
  if (SYNC_STAGES != 3)
  begin : g_sync_depth
    $error("the pin filter is built for three stages");
  end

  // the reset value must fill the counter exactly
  if ($bits(COUNT_RESET) != COUNT_W)
  begin : g_count_width
    $error("count reset value does not match the counter width");
  end

  // the decoder works on one phase pair: two pins, no more
  if ($bits(enc_phase_t) != 2)
  begin : g_phase_width
    $error("the phase carrier must hold exactly two pins");
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  // three stages; a change counts only once stages two and three agree, so a
  // single unsettled sample in stage one is never taken as a level
  logic [1:0]       ph_s1_q;
  logic [1:0]       ph_s2_q;
  logic [1:0]       ph_s3_q;
  logic [1:0]       ph_q;
  logic [TERMS-1:0] tm_s1_q;
  logic [TERMS-1:0] tm_s2_q;
  logic [TERMS-1:0] tm_s3_q;
  logic [TERMS-1:0] tm_q;

  // keep the last accepted level of a bit until stages two and three agree
  function automatic logic settle_bit(input logic held,
                                      input logic late,
                                      input logic last);
    settle_bit = (late == last) ? last : held;
  endfunction

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ph_s1_q <= PHASE_RESET;
      ph_s2_q <= PHASE_RESET;
      ph_s3_q <= PHASE_RESET;
      ph_q    <= PHASE_RESET;
    end
    else if (ce_in)
    begin
      ph_s1_q <= {enc_in.phase_b, enc_in.phase_a};
      ph_s2_q <= ph_s1_q;
      ph_s3_q <= ph_s2_q;
      // per-bit filter so each phase edge is seen exactly once; both bits
      // moving on one cycle is left for the decoder to refuse
      for (int i = 0; i < 2; i++)
      begin
        ph_q[i] <= settle_bit(ph_q[i], ph_s2_q[i], ph_s3_q[i]);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tm_s1_q <= '0;
      tm_s2_q <= '0;
      tm_s3_q <= '0;
      tm_q    <= '0;
    end
    else if (ce_in)
    begin
      tm_s1_q <= term_in;
      tm_s2_q <= tm_s1_q;
      tm_s3_q <= tm_s2_q;
      // terminals share the filter; each bit settles on its own
      for (int i = 0; i < TERMS; i++)
      begin
        tm_q[i] <= settle_bit(tm_q[i], tm_s2_q[i], tm_s3_q[i]);
      end
    end
  end

  // --------------------------------------------------------------------------
  // start-up reference
  // --------------------------------------------------------------------------
  // the encoder may rest in any of its four states when reset ends; the
  // first settled pair becomes the reference and is never counted, else a
  // false step would follow a reset with the pins at 01 or 10; the trade: an edge that arrives in
  // the first cycles after reset is absorbed into the reference
  localparam int unsigned PRIME_CYCLES = SYNC_STAGES + 3;

  logic [2:0] prime_cnt_q;
  logic       primed;

  assign primed = (prime_cnt_q == 3'(PRIME_CYCLES));

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      prime_cnt_q <= 3'h0;
    else if (ce_in && !primed)
      prime_cnt_q <= 3'(prime_cnt_q + 3'h1);
  end

  // --------------------------------------------------------------------------
  // quadrature decode
  // --------------------------------------------------------------------------
  // prev_q is the filtered pair of the cycle before; a legal move changes
  // one bit of it; both bits moving at once (a glitch, or pins too fast for
  // the filter) gives no direction, so it is dropped rather than guessed
  logic [1:0] prev_q;
  logic       step_up;
  logic       step_dn;

  function automatic logic [1:0] gray_pos(input logic [1:0] ba);
    // position of the phase pair in the forward cycle 00,01,11,10
    case (ba)
      2'h0:    gray_pos = 2'h0;
      2'h1:    gray_pos = 2'h1;
      2'h3:    gray_pos = 2'h2;
      default: gray_pos = 2'h3;
    endcase
  endfunction

  always_comb
  begin
    logic [1:0] delta;
    delta   = 2'(gray_pos(ph_q) - gray_pos(prev_q));
    step_up = 1'b0;
    step_dn = 1'b0;
    if (primed)
    begin
      case (delta)
        2'h1:    step_up = 1'b1;
        2'h3:    step_dn = 1'b1;
        default: step_up = 1'b0; // no move, or both phases at once
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      prev_q <= PHASE_RESET;
    else if (ce_in)
      prev_q <= ph_q;
  end

  // --------------------------------------------------------------------------
  // position counter
  // --------------------------------------------------------------------------
  // modular arithmetic wraps both ways with no special case; the cast makes
  // the dropped carry deliberate
  logic [COUNT_W-1:0] count_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      count_q <= COUNT_RESET;
    else if (ce_in)
    begin
      if (step_up)
        count_q <= COUNT_W'(count_q + 1'b1);
      else if (step_dn)
        count_q <= COUNT_W'(count_q - 1'b1);
    end
  end

  // sense of the last accepted step; it holds through idle time
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      dir_reverse_out <= 1'b0;
    else if (ce_in)
    begin
      if (step_dn)
        dir_reverse_out <= 1'b1;
      else if (step_up)
        dir_reverse_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // monitor output
  // --------------------------------------------------------------------------
  // a registered copy: reading never touches the counter itself
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      monitor_out <= '0;
    else if (ce_in)
    begin
      monitor_out.encoder_position_monitor <= count_q;
      monitor_out.input_state_monitor      <= tm_q;
    end
  end

endmodule // quadrature_position_counter

/* test/qpc_monitor.sv */
// port assertions for the position counter
`timescale 1ns/1ps
module qpc_monitor import qpc_pkg::*; #(parameter int unsigned TERMS = TERM_W) (
  input wire logic             clk_in,
  input wire logic             rst_in,
  input wire logic             ce_in,
  input wire enc_phase_t       enc_in,
  input wire logic [TERMS-1:0] term_in,
  input wire monitor_t         monitor_out,
  input wire logic             dir_reverse_out
);
  wire [15:0] p = monitor_out.encoder_position_monitor;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // wrap both ways is plain modular step by one
  chk_pos_step: assert property ($changed(p) |-> 16'(p - $past(p)) == 16'h0001
    || 16'(p - $past(p)) == 16'hffff) else $error("bad step");
  // flag and count move on one edge, the position view one enabled edge later
  chk_up_fwd: assert property (16'(p - $past(p)) == 16'h0001 |-> !$past(dir_reverse_out))
    else $error("up not fwd");
  chk_down_rev: assert property (16'(p - $past(p)) == 16'hffff |-> $past(dir_reverse_out))
    else $error("down not rev");
  chk_ce_freeze: assert property (!ce_in |=> $stable(monitor_out)) else $error("not frozen");
  chk_term_view: assert property ((ce_in && $stable(term_in))[*8]
    |-> monitor_out.input_state_monitor == term_in) else $error("term view");
  chk_pins_only: assert property ((ce_in && $stable(enc_in))[*8] |-> $stable(p))
    else $error("count w/o pins");
  chk_step_seen: assert property (ce_in && $countones(enc_in ^ $past(enc_in)) == 1
    ##1 (ce_in && $stable(enc_in))[*4] |-> ##[1:3] $changed(p)) else $error("step lost");
  chk_reset_zero: assert property (disable iff (1'b0) rst_in |=> monitor_out == '0)
    else $error("reset value");
  cover property (p == 16'hffff);
  cover property ($rose(dir_reverse_out));
  cover property (!ce_in ##1 ce_in);
endmodule // qpc_monitor
bind quadrature_position_counter qpc_monitor #(.TERMS(TERMS)) mon_i (
  .clk_in          (clk_in),
  .rst_in          (rst_in),
  .ce_in           (ce_in),
  .enc_in          (enc_in),
  .term_in         (term_in),
  .monitor_out     (monitor_out),
  .dir_reverse_out (dir_reverse_out)
);

/* test/encoder_model.sv */
// behavioural incremental encoder on the phase pins
`timescale 1ns/1ps
module encoder_model (
  input  wire logic           clk_in,
  output qpc_pkg::enc_phase_t enc_out
);
  logic [1:0] s_q = 2'h0;
  // gray order moves one phase a step; inc 2 jumps both on purpose
  assign enc_out = {s_q[1], s_q[1] ^ s_q[0]};
  task step(input logic [1:0] inc, input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(posedge clk_in);
      #1 s_q = s_q + inc;
    end
  endtask
endmodule // encoder_model

/* test/tb_quadrature_position_counter.sv */
// self-checking bench for the position counter
`timescale 1ns/1ps
module tb_quadrature_position_counter;
  import qpc_pkg::*;
  logic        clk_in  = 1'b0;
  logic        rst_in  = 1'b1;
  logic        ce_in   = 1'b1;
  logic [7:0]  term_in = 8'h00;
  logic [15:0] pos     = 16'h0000;
  enc_phase_t  enc;
  monitor_t    mon;
  logic        rev;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  initial forever #5 clk_in = ~clk_in;
  encoder_model enc_m (.clk_in(clk_in), .enc_out(enc));
  quadrature_position_counter dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .enc_in(enc), .term_in(term_in), .monitor_out(mon), .dir_reverse_out(rev));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // settle margin covers the six-edge pin-to-output latency
  task turn(input logic [1:0] inc, input int n, input int gap);
    enc_m.step(inc, n, gap);
    repeat (10) @(posedge clk_in);
    #1;
  endtask
  task t_forward;
    turn(2'h1, 8, 4);
    pos = pos + 16'h0008;
    check(mon.encoder_position_monitor, pos);
    check({15'h0, rev}, 16'h0000);
    $display("forward done");
  endtask
  task t_reverse;
    turn(2'h3, 10, 12);
    pos = pos - 16'h000a;
    check(mon.encoder_position_monitor, pos);
    check({15'h0, rev}, 16'h0001);
    $display("reverse done");
  endtask
  task t_wrap_up;
    turn(2'h1, 2, 4);
    pos = pos + 16'h0002;
    check(mon.encoder_position_monitor, 16'h0000);
    check({15'h0, rev}, 16'h0000);
    $display("wrap done");
  endtask
  task t_freeze;
    ce_in = 1'b0;
    term_in = 8'ha5;
    turn(2'h1, 4, 4);
    ce_in = 1'b1;
    turn(2'h2, 2, 4);
    check(mon.encoder_position_monitor, 16'h0000);
    check({8'h00, mon.input_state_monitor}, 16'h00a5);
    $display("freeze done");
  endtask
  // reset while the encoder rests off its idle state: no false step after it
  task t_restart;
    turn(2'h1, 1, 4);
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 rst_in = 1'b0;
    turn(2'h1, 1, 4);
    pos = 16'h0001;
    check(mon.encoder_position_monitor, pos);
    check({15'h0, rev}, 16'h0000);
    $display("restart done");
  endtask
  task summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'b0;
    t_forward();
    t_reverse();
    t_wrap_up();
    t_freeze();
    t_restart();
    summarize();
  end
endmodule // tb_quadrature_position_counter
